/* hdl/adc_result_slots.sv */
// Purpose: result slots 5 to 7 of the converter, read over APB
// Assumes: sequencer runs on clk_sys; software uses 16/32-bit reads
// Notes:   read flags clear one cycle after the data is returned
//
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/1ps

module adc_result_slots (
  // clock and reset
  input  wire logic                      clk_sys,
  input  wire logic                      rst_b,
  // apb slave
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [7:0]                paddr,
  input  wire logic [31:0]               pwdata,
  input  wire logic [3:0]                pstrb,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  // sequencer result write
  input  wire adc_slot_pkg::result_wr_t  resultWr,
  // interrupt
  output logic                           irq
);

  // slot storage
  adc_slot_pkg::slot_state_t slot_ff     [adc_slot_pkg::NUM_SLOTS];
  adc_slot_pkg::slot_state_t nxt_slot    [adc_slot_pkg::NUM_SLOTS];
  logic [adc_slot_pkg::IRQ_W-1:0] irqStat_ff;
  logic [adc_slot_pkg::IRQ_W-1:0] nxt_irqStat;
  logic [adc_slot_pkg::IRQ_W-1:0] irqMask_ff;
  logic [31:0]                    prdata_ff;
  logic                           pready_ff;
  logic                           pslverr_ff;
  logic                           irq_ff;
  logic [adc_slot_pkg::NUM_SLOTS-1:0] clrPend_ff;
  logic [adc_slot_pkg::NUM_SLOTS-1:0] nxt_clrPend;

  // next state of one slot; a result write beats a read-clear landing in the same cycle
  function automatic adc_slot_pkg::slot_state_t nextSlot(
    input adc_slot_pkg::slot_state_t cur,
    input logic                      clr,
    input logic                      wr,
    input logic [9:0]                val
  );
    adc_slot_pkg::slot_state_t n;
    n = cur;
    // read-clear drops both flags once the data has gone out
    if (clr) begin
      n.overrun   = 1'b0;
      n.available = 1'b0;
    end
    // a landing clear means the old result was read, so no overrun then
    if (wr) begin
      n.value     = val;
      n.available = 1'b1;
      if (cur.available && !clr)
        n.overrun = 1'b1;
    end
    return n;
  endfunction : nextSlot

  // pack a slot into its 32-bit register image
  function automatic logic [31:0] slotWord(input adc_slot_pkg::slot_state_t s);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[adc_slot_pkg::VALUE_LSB +: adc_slot_pkg::VALUE_W] = s.value;
    w[adc_slot_pkg::OVERRUN_BIT]   = s.overrun;
    w[adc_slot_pkg::AVAILABLE_BIT] = s.available;
    return w;
  endfunction : slotWord

  // bus decode: access phase of a transfer, answered one cycle later
  wire        access    = psel && penable;
  wire        rdAcc     = access && !pwrite;
  wire        wrAcc     = access && pwrite;
  wire        hitSlot5  = (paddr == adc_slot_pkg::OFS_SLOT5);
  wire        hitSlot6  = (paddr == adc_slot_pkg::OFS_SLOT6);
  wire        hitSlot7  = (paddr == adc_slot_pkg::OFS_SLOT7);
  wire        hitStat   = (paddr == adc_slot_pkg::OFS_IRQ_STAT);
  wire        hitMask   = (paddr == adc_slot_pkg::OFS_IRQ_MASK);
  wire        hitAny    = hitSlot5 | hitSlot6 | hitSlot7 | hitStat | hitMask;
  wire [2:0]  hitSlot   = {hitSlot7, hitSlot6, hitSlot5};
  // slots are read-only; a write to them is an error, not a silent drop
  wire        badAcc    = !hitAny || (wrAcc && (|hitSlot));
  // read data from the current state, before any clear
  wire [31:0] rdMux     = hitSlot5 ? slotWord(slot_ff[0]) :
                          hitSlot6 ? slotWord(slot_ff[1]) :
                          hitSlot7 ? slotWord(slot_ff[2]) :
                          hitStat  ? {26'h000_0000, irqStat_ff} :
                          hitMask  ? {26'h000_0000, irqMask_ff} : 32'h0000_0000;
  // byte reads only happen if software breaks the 16/32-bit contract
  // armed from the first access cycle only: re-arming on the answer cycle
  // would wipe a result written on that very edge
  wire        rdClr     = rdAcc && !pready_ff && !badAcc;

  // result write decode; slot code 3 matches no slot and is dropped
  wire [2:0]  wrHit     = {resultWr.strobe && (resultWr.slot == 2'd2),
                           resultWr.strobe && (resultWr.slot == 2'd1),
                           resultWr.strobe && (resultWr.slot == 2'd0)};

  // clear lands the cycle after the read data was captured
  assign nxt_clrPend    = hitSlot & {3{rdClr}};

  // next slot state; one function keeps the three slots alike
  assign nxt_slot[0]    = nextSlot(slot_ff[0], clrPend_ff[0], wrHit[0], resultWr.value);
  assign nxt_slot[1]    = nextSlot(slot_ff[1], clrPend_ff[1], wrHit[1], resultWr.value);
  assign nxt_slot[2]    = nextSlot(slot_ff[2], clrPend_ff[2], wrHit[2], resultWr.value);

  // flag edges feed the sticky status bits
  wire [2:0]  availRise = {nxt_slot[2].available & ~slot_ff[2].available,
                           nxt_slot[1].available & ~slot_ff[1].available,
                           nxt_slot[0].available & ~slot_ff[0].available};
  wire [2:0]  ovrRise   = {nxt_slot[2].overrun & ~slot_ff[2].overrun,
                           nxt_slot[1].overrun & ~slot_ff[1].overrun,
                           nxt_slot[0].overrun & ~slot_ff[0].overrun};
  wire [5:0]  statClr   = (wrAcc && hitStat && pstrb[0]) ? pwdata[adc_slot_pkg::IRQ_W-1:0] : 6'h00;
  // set wins, so an event in the clearing cycle is never lost
  assign nxt_irqStat    = {ovrRise, availRise} | (irqStat_ff & ~statClr);

  // slot storage
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < adc_slot_pkg::NUM_SLOTS; i++) begin
        slot_ff[i] <= adc_slot_pkg::slot_state_t'(12'h000);
      end
    end else begin
      slot_ff <= nxt_slot;
    end
  end

  // pending read-clears
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      clrPend_ff <= '0;
    end else begin
      clrPend_ff <= nxt_clrPend;
    end
  end

  // sticky interrupt status
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      irqStat_ff <= '0;
    end else begin
      irqStat_ff <= nxt_irqStat;
    end
  end

  // mask register, low byte lane only
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b)
      irqMask_ff <= adc_slot_pkg::IRQ_MASK_RESET;
    else if (wrAcc && hitMask && pstrb[0])
      irqMask_ff <= pwdata[adc_slot_pkg::IRQ_W-1:0];
  end

  // bus outputs registered: answer one cycle after the access phase opens
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= adc_slot_pkg::SLOT_RESET;
      irq_ff     <= 1'b0;
    end else begin
      pready_ff  <= access && !pready_ff;
      pslverr_ff <= access && !pready_ff && badAcc;
      prdata_ff  <= (rdAcc && !pready_ff && !badAcc) ? rdMux : 32'h0000_0000;
      irq_ff     <= |(nxt_irqStat & irqMask_ff);
    end
  end

  assign prdata  = prdata_ff;
  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;
  assign irq     = irq_ff;

endmodule : adc_result_slots

/* hdl/adc_slot_pkg.sv */
// Purpose: shared constants and types for the conversion result slots
// Assumes: 32-bit register bus, word-aligned registers
// Notes:   offsets and interrupt registers are local choices
package adc_slot_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_SLOT5     = 8'h00;
  localparam logic [7:0] OFS_SLOT6     = 8'h04;
  localparam logic [7:0] OFS_SLOT7     = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h0C;
  localparam logic [7:0] OFS_IRQ_MASK  = 8'h10;

  // field layout of a result slot
  localparam int VALUE_LSB     = 6;
  localparam int VALUE_W       = 10;
  localparam int OVERRUN_BIT   = 1;
  localparam int AVAILABLE_BIT = 0;
  localparam int NUM_SLOTS     = 3;

  // interrupt status layout: bits 2..0 fresh result, bits 5..3 overrun
  localparam int IRQ_W         = 6;

  // reset values
  localparam logic [31:0] SLOT_RESET     = 32'h0000_0000;
  localparam logic [5:0]  IRQ_MASK_RESET = 6'h00;

  // result write from the conversion sequencer
  typedef struct packed {
    logic       strobe;
    logic [1:0] slot;
    logic [9:0] value;
  } result_wr_t;

  // state held by one slot
  typedef struct packed {
    logic [9:0] value;
    logic       overrun;
    logic       available;
  } slot_state_t;

endpackage : adc_slot_pkg

/* testbench/adc_result_slots_monitor.sv */
// Purpose: port checks on the result slot flags
// Assumes: one wait state; slot5 sits at offset 0x00
// Notes:   flag checks watch slot5 only, to stay small
`timescale 1ns/1ps
module adc_result_slots_monitor (
  // clock and reset
  input wire logic                     clk_sys,
  input wire logic                     rst_b,
  // bus and sequencer
  input wire logic                     psel,
  input wire logic                     pwrite,
  input wire logic [7:0]               paddr,
  input wire logic [31:0]              prdata,
  input wire logic                     pready,
  input wire adc_slot_pkg::result_wr_t resultWr
);
  // completed slot5 read and slot5 result write
  wire rd5 = psel && pready && !pwrite && paddr == adc_slot_pkg::OFS_SLOT5;
  wire wr5 = resultWr.strobe && resultWr.slot == 2'd0;
  wire rdSlot = psel && pready && !pwrite && paddr < adc_slot_pkg::OFS_IRQ_STAT;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  reserved_zero_a: assert property (rdSlot |-> prdata[31:16] == 16'h0000 && prdata[5:2] == 4'h0)
    else $error("reserved slot bits not zero");
  overrun_set_a: assert property (wr5 ##2 wr5 ##4 rd5 |-> prdata[1:0] == 2'b11)
    else $error("overrun missing after double write");
  // quiet gap of four cycles lets the pending clear land
  overrun_clear_a: assert property ((rd5 && !resultWr.strobe) ##1 !resultWr.strobe [*4] ##0 rd5 |-> !prdata[1])
    else $error("overrun survived a read");
  avail_set_a: assert property (wr5 ##4 rd5 |-> prdata[0])
    else $error("available missing after write");
  avail_clear_a: assert property ((rd5 && !resultWr.strobe) ##1 !resultWr.strobe [*4] ##0 rd5 |-> !prdata[0])
    else $error("available survived a read");
  write_wins_a: assert property ((rd5 && wr5) ##4 rd5 |-> prdata[0])
    else $error("result written during read was lost");
endmodule : adc_result_slots_monitor

bind adc_result_slots adc_result_slots_monitor i_mon (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .resultWr(resultWr));

/* testbench/tb_adc_result_slots.sv */
// Purpose: self-checking bench for the result slots
// Assumes: bus answers after one wait state
// Notes:   irq is checked after a bus read, so it has settled
`timescale 1ns/1ps
module tb_adc_result_slots;
  logic                     clk_sys, rst_b, psel, penable, pwrite, pready, pslverr, irq, err;
  logic [7:0]               paddr;
  logic [31:0]              pwdata, prdata, r;
  adc_slot_pkg::result_wr_t resultWr;
  int                       error_cnt, compares, cyc;
  adc_result_slots i_dut (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .resultWr(resultWr), .irq(irq));
  // 100 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // hang guard, far above the hundred or so cycles used
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      complete_run();
    end
  end
  task automatic complete_run;
    if (error_cnt == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // one transfer, held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // one-cycle result strobe; the trailing edge keeps writes two cycles apart
  task automatic post(input logic [1:0] s, input logic [9:0] v);
    @(posedge clk_sys);
    resultWr <= '{1'b1, s, v};
    @(posedge clk_sys);
    resultWr.strobe <= 1'b0;
  endtask : post
  initial begin
    {rst_b, psel, penable, pwrite, paddr, pwdata, resultWr} = '0;
    repeat (16) @(posedge clk_sys);
    rst_b <= 1'b1;
    for (int s = 0; s < 3; s++) begin
      apb(1'b0, 8'(4 * s), 32'h0000_0000);
      chk(r, 32'h0000_0000);
      post(2'(s), 10'h3ff - 10'(s));
      apb(1'b0, 8'(4 * s), 32'h0000_0000);
      chk(r, {16'h0000, 10'h3ff - 10'(s), 6'h01});
      apb(1'b0, 8'(4 * s), 32'h0000_0000);
      chk(r, {16'h0000, 10'h3ff - 10'(s), 6'h00});
    end
    post(2'd0, 10'h155);
    post(2'd0, 10'h2aa);
    apb(1'b0, adc_slot_pkg::OFS_SLOT5, 32'h0000_0000);
    chk(r, 32'h0000_aa83);
    apb(1'b0, adc_slot_pkg::OFS_SLOT5, 32'h0000_0000);
    chk(r, 32'h0000_aa80);
    // new result lands on the read's answer edge
    fork
      apb(1'b0, adc_slot_pkg::OFS_SLOT5, 32'h0000_0000);
      begin
        repeat (2) @(posedge clk_sys);
        post(2'd0, 10'h001);
      end
    join
    chk(r, 32'h0000_aa80);
    apb(1'b0, adc_slot_pkg::OFS_SLOT5, 32'h0000_0000);
    chk(r, 32'h0000_0041);
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk({31'h0, err}, 32'h0000_0001);
    // slots are read-only; slot code 3 must touch nothing
    apb(1'b1, adc_slot_pkg::OFS_SLOT5, 32'h0000_ffff);
    chk({31'h0, err}, 32'h0000_0001);
    post(2'd3, 10'h3ff);
    apb(1'b0, adc_slot_pkg::OFS_SLOT7, 32'h0000_0000);
    chk(r, {16'h0000, 10'h3fd, 6'h00});
    // interrupt: raise, mask open, clear
    apb(1'b1, adc_slot_pkg::OFS_IRQ_STAT, 32'h0000_003f);
    post(2'd2, 10'h000);
    apb(1'b0, adc_slot_pkg::OFS_IRQ_STAT, 32'h0000_0000);
    chk(r, 32'h0000_0004);
    chk({31'h0, irq}, 32'h0000_0000);
    apb(1'b1, adc_slot_pkg::OFS_IRQ_MASK, 32'h0000_0004);
    apb(1'b0, adc_slot_pkg::OFS_IRQ_MASK, 32'h0000_0000);
    chk(r, 32'h0000_0004);
    chk({31'h0, irq}, 32'h0000_0001);
    apb(1'b1, adc_slot_pkg::OFS_IRQ_STAT, 32'h0000_0004);
    apb(1'b0, adc_slot_pkg::OFS_IRQ_STAT, 32'h0000_0000);
    chk(r, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0000_0000);
    complete_run();
  end
endmodule : tb_adc_result_slots
